// ===== common/dvm_pkg.sv
// Package for the core ramp and linear regulator select registers.
// Assumes a 20 MHz clock and a parallel register port behind the serial link.
package dvm_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] RAMP_ADDR = 8'h07;
   localparam logic [7:0] LREG_ADDR = 8'h08;
   localparam logic [7:0] RAMP_RESET = 8'h06;
   localparam logic [7:0] RAMP_MASK = 8'h07;
   localparam logic [7:0] LREG_MASK = 8'h77;
   localparam int REG_A_LSB = 0;
   localparam int REG_B_LSB = 4;
   localparam logic [2:0] RAMP_IMMEDIATE = 3'h7;

   // Strap pair {b,a} to default select byte; values are arbitrary
   localparam logic [7:0] STRAP_DEFAULT [4] = '{8'h00, 8'h31, 8'h53, 8'h77};

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 20;
   localparam int CORE_STEP_UV = 25000;
   localparam int RATE_UV_PER_US [7] = '{150, 300, 600, 1200, 2400, 4800, 9600};
   localparam int STEP_CNT_W = 12;
   localparam logic [1:0] INIT_WAIT = 2'h3;
   localparam logic [4:0] CORE_RESET = 5'h14;

   // Cycles per 25 mV code step at the selected rate
   function automatic logic [STEP_CNT_W-1:0] step_cycles(input logic [2:0] code);
      int c;
      c = 1;
      if (code != RAMP_IMMEDIATE) begin
         c = (CORE_STEP_UV * CLK_MHZ) / RATE_UV_PER_US[code];
      end
      return STEP_CNT_W'(c);
   endfunction : step_cycles

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dvm_req_s;

endpackage : dvm_pkg

// ===== rtl/dvm_regs.sv
// Core ramp rate select, linear regulator select and core code stepper.
// Assumes the serial interface presents decoded register accesses on clk_i.
//
// Overview of operation
// - Ramp code selects 0.15 to 9.6 mV/us; code 111 jumps core code at once.
// - Ramp register at 0x07, read/write, resets and reloads 0x06 on lockout.
// - Regulator register at 0x08: B code bits 6:4, A code bits 2:0.
// - Regulator A codes map to 1, 1.1, 1.35, 1.5, 2.2, 2.6, 2.85, 3.15 V.
// - Regulator B codes map to 1.05, 1.2, 1.3, 1.8, 2.5, 2.8, 3, 3.3 V.
// - On lockout, regulator codes reload from defaults chosen by strap pins.
// - Trigger steps core code at ramp rate; clears itself when target reached.
`timescale 1ns/1ps
module dvm_regs
   import dvm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire dvm_req_s req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Pins
   input wire logic undervoltage_lockout_i,
   input wire logic reg_strap_pin_a_i,
   input wire logic reg_strap_pin_b_i,
   // Core transition
   input wire logic [4:0] core_voltage_code_i,
   input wire logic core_go_set_i,
   output logic core_go_o,
   output logic [4:0] core_converter_code_o,
   // Regulator settings
   output logic [2:0] ramp_code_o,
   output logic [11:0] reg_a_mv_o,
   output logic [11:0] reg_b_mv_o
);

   // ****************************************
   // Decode functions
   // ****************************************
   function automatic logic [11:0] reg_a_mv(input logic [2:0] c);
      logic [11:0] t [8];
      t = '{12'h3E8, 12'h44C, 12'h546, 12'h5DC, 12'h898, 12'hA28, 12'hB22, 12'hC4E};
      return t[c];
   endfunction : reg_a_mv

   function automatic logic [11:0] reg_b_mv(input logic [2:0] c);
      logic [11:0] t [8];
      t = '{12'h41A, 12'h4B0, 12'h514, 12'h708, 12'h9C4, 12'hAF0, 12'hBB8, 12'hCE4};
      return t[c];
   endfunction : reg_b_mv

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic lockout_s;
   logic [1:0] strap_s;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         meta_q <= {undervoltage_lockout_i, reg_strap_pin_b_i, reg_strap_pin_a_i};
         sync_q <= meta_q;
      end
   end

   assign lockout_s = sync_q[2];
   assign strap_s = sync_q[1:0];

   // ****************************************
   // Default loading
   // ****************************************
   logic [1:0] init_q;
   logic init_load;
   logic load_def;
   logic [7:0] strap_def;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         init_q <= INIT_WAIT;
      end else if (init_q != 2'h0) begin
         init_q <= init_q - 2'h1;
      end
   end

   assign init_load = (init_q == 2'h1);
   assign load_def = lockout_s || init_load;
   assign strap_def = STRAP_DEFAULT[strap_s] & LREG_MASK;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ramp_q;
   logic [7:0] lreg_q;
   logic wr_ramp;
   logic wr_lreg;
   logic [7:0] rd_mux;

   assign wr_ramp = req_i.wr && (req_i.addr == RAMP_ADDR);
   assign wr_lreg = req_i.wr && (req_i.addr == LREG_ADDR);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ramp_q <= RAMP_RESET;
      end else if (lockout_s) begin
         ramp_q <= RAMP_RESET;
      end else if (wr_ramp) begin
         ramp_q <= req_i.wdata & RAMP_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         lreg_q <= STRAP_DEFAULT[0];
      end else if (load_def) begin
         lreg_q <= strap_def;
      end else if (wr_lreg) begin
         lreg_q <= req_i.wdata & LREG_MASK;
      end
   end

   assign rd_mux = (req_i.addr == RAMP_ADDR) ? ramp_q :
                   (req_i.addr == LREG_ADDR) ? lreg_q : 8'h00;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            rdata_o <= rd_mux;
         end
      end
   end

   // ****************************************
   // Regulator voltage outputs
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reg_a_mv_o <= 12'h000;
         reg_b_mv_o <= 12'h000;
      end else begin
         reg_a_mv_o <= reg_a_mv(lreg_q[REG_A_LSB +: 3]);
         reg_b_mv_o <= reg_b_mv(lreg_q[REG_B_LSB +: 3]);
      end
   end

   assign ramp_code_o = ramp_q[2:0];

   // ****************************************
   // Core code stepper
   // ****************************************
   logic go_q;
   logic [4:0] core_q;
   logic [STEP_CNT_W-1:0] cnt_q;
   logic at_target;
   logic immediate;
   logic step_due;
   logic [4:0] core_next;

   assign at_target = (core_q == core_voltage_code_i);
   assign immediate = (ramp_q[2:0] == RAMP_IMMEDIATE);
   assign step_due = go_q && !at_target && (immediate || cnt_q == 12'h001);
   assign core_next = immediate ? core_voltage_code_i :
                      (core_q < core_voltage_code_i) ? core_q + 5'h01 : core_q - 5'h01;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         go_q <= 1'b0;
      end else if (core_go_set_i) begin
         go_q <= 1'b1;
      end else if (go_q && at_target) begin
         go_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         core_q <= CORE_RESET;
      end else if (step_due) begin
         core_q <= core_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_q <= 12'h001;
      end else if (!go_q || step_due || cnt_q == 12'h001) begin
         cnt_q <= step_cycles(ramp_q[2:0]);
      end else begin
         cnt_q <= cnt_q - 12'h001;
      end
   end

   assign core_go_o = go_q;
   assign core_converter_code_o = core_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_lockout;
      lockout_s;
   endsequence
   sequence s_reloaded;
      ramp_q == RAMP_RESET && lreg_q == strap_def;
   endsequence

   property p_ramp_reload;
      s_lockout |=> s_reloaded;
   endproperty
   a_ramp_reload: assert property (p_ramp_reload) else $error("lockout reload wrong");

   property p_ramp_read;
      req_i.rd && req_i.addr == RAMP_ADDR |=> rvalid_o && rdata_o == $past(ramp_q);
   endproperty
   a_ramp_read: assert property (p_ramp_read) else $error("ramp read wrong");

   property p_lreg_write;
      req_i.wr && req_i.addr == LREG_ADDR && !load_def |=> lreg_q == ($past(req_i.wdata) & 8'h77);
   endproperty
   a_lreg_write: assert property (p_lreg_write) else $error("regulator write wrong");

   property p_unused_zero;
      ramp_q[7:3] == 5'h00 && lreg_q[7] == 1'b0 && lreg_q[3] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

   property p_reg_a_map;
      lreg_q[2:0] == 3'h2 && $stable(lreg_q) |=> reg_a_mv_o == 12'h546;
   endproperty
   a_reg_a_map: assert property (p_reg_a_map) else $error("regulator A map wrong");

   property p_reg_b_map;
      lreg_q[6:4] == 3'h3 && $stable(lreg_q) |=> reg_b_mv_o == 12'h708;
   endproperty
   a_reg_b_map: assert property (p_reg_b_map) else $error("regulator B map wrong");

   property p_immediate;
      go_q && immediate && !at_target && !lockout_s |=> core_q == $past(core_voltage_code_i);
   endproperty
   a_immediate: assert property (p_immediate) else $error("immediate jump missing");

   property p_fast_spacing;
      go_q && ramp_q[2:0] == 3'h6 && $changed(core_q) && !$changed(ramp_q)
         |=> !$changed(core_q) [*8];
   endproperty
   a_fast_spacing: assert property (p_fast_spacing) else $error("step too early");

   property p_go_clear;
      go_q && at_target && !core_go_set_i |=> !go_q;
   endproperty
   a_go_clear: assert property (p_go_clear) else $error("trigger not cleared");

   property p_go_set_wins;
      core_go_set_i |=> go_q;
   endproperty
   a_go_set_wins: assert property (p_go_set_wins) else $error("trigger set lost");

endmodule : dvm_regs

// ===== verification/test_dvm_regs.sv
// Self-checking bench for the ramp and regulator select registers.
// Assumes dvm_pkg is compiled first; drives all ports directly.
`timescale 1ns/1ps
module test_dvm_regs;
   import dvm_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   dvm_req_s req_i = '0;
   logic [7:0] rdata_o;
   logic rvalid_o;
   logic lockout = 1'b0;
   logic strap_a;
   logic strap_b;
   logic [4:0] tgt = 5'h14;
   logic go_set = 1'b0;
   logic core_go_o;
   logic [4:0] core_code;
   logic [2:0] ramp_code_o;
   logic [11:0] reg_a_mv_o;
   logic [11:0] reg_b_mv_o;
   int n_fail = 0;
   int tests_run = 0;
   int seed = 63913;
   localparam logic [11:0] MVA [8] = '{12'h3E8, 12'h44C, 12'h546, 12'h5DC,
      12'h898, 12'hA28, 12'hB22, 12'hC4E};
   localparam logic [11:0] MVB [8] = '{12'h41A, 12'h4B0, 12'h514, 12'h708,
      12'h9C4, 12'hAF0, 12'hBB8, 12'hCE4};
   always #25 clk_i = ~clk_i;
   dvm_regs i_dvm_regs (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .undervoltage_lockout_i(lockout),
      .reg_strap_pin_a_i(strap_a), .reg_strap_pin_b_i(strap_b),
      .core_voltage_code_i(tgt), .core_go_set_i(go_set), .core_go_o(core_go_o),
      .core_converter_code_o(core_code), .ramp_code_o(ramp_code_o),
      .reg_a_mv_o(reg_a_mv_o), .reg_b_mv_o(reg_b_mv_o));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_i);
      req_i = '0;
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk_i);
      req_i = '0;
      chk(rvalid_o, 1'b1);
      chk(rdata_o, exp);
   endtask : rdchk
   task automatic outs(input logic [7:0] rmp, input logic [7:0] lr);
      chk(ramp_code_o, rmp[2:0]);
      chk(reg_a_mv_o, MVA[lr[2:0]]);
      chk(reg_b_mv_o, MVB[lr[6:4]]);
   endtask : outs
   function automatic int step_n(input logic [2:0] c);
      int r [7] = '{150, 300, 600, 1200, 2400, 4800, 9600};
      if (c == 3'h7) return 1;
      return 500000 / r[c];
   endfunction : step_n
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      #(50 * 40000);
      n_fail++;
      $display("watchdog expired");
      final_report();
   end
   initial begin
      logic [7:0] rmp, lr, d, s, a;
      int cnt, n;
      {strap_b, strap_a} = 2'($random(seed));
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (6) @(negedge clk_i);
      rmp = RAMP_RESET;
      lr = STRAP_DEFAULT[{strap_b, strap_a}];
      rdchk(8'h07, 8'h06);
      rdchk(8'h08, lr);
      outs(rmp, lr);
      $display("reset test done");
      wr(8'h07, 8'hFF);
      wr(8'h08, 8'hFF);
      rdchk(8'h07, 8'h07);
      rdchk(8'h08, 8'h77);
      for (int c = 0; c < 8; c++) begin
         lr = {1'b1, 3'(c), 1'b1, ~3'(c)};
         wr(8'h08, lr);
         lr = lr & LREG_MASK;
         rdchk(8'h08, lr);
         outs(8'h07, lr);
      end
      rmp = 8'h07;
      for (int i = 0; i < 24; i++) begin
         d = 8'($random(seed));
         s = 8'($random(seed));
         a = (s[1:0] == 2'h0) ? 8'h07 : (s[1:0] == 2'h1) ? 8'h08 : {2'b01, s[7:2]};
         wr(a, d);
         if (a == 8'h07) rmp = d & RAMP_MASK;
         if (a == 8'h08) lr = d & LREG_MASK;
         rdchk(a, (a == 8'h07) ? rmp : (a == 8'h08) ? lr : 8'h00);
         outs(rmp, lr);
      end
      $display("register test done");
      for (int c = 0; c < 8; c++) begin
         wr(8'h07, 8'(c));
         tgt = (c % 2 == 0) ? 5'h16 : 5'h14;
         go_set = 1'b1;
         @(negedge clk_i);
         go_set = 1'b0;
         chk(core_go_o, 1'b1);
         cnt = 0;
         while (core_go_o === 1'b1 && cnt < 8000) begin
            @(negedge clk_i);
            cnt++;
         end
         n = (c == 7) ? 1 : 2 * step_n(3'(c));
         chk(cnt >= n && cnt <= n + 4, 1'b1);
         chk(core_code, tgt);
      end
      $display("ramp test done");
      @(negedge clk_i);
      lockout = 1'b1;
      {strap_b, strap_a} = ~{strap_b, strap_a};
      repeat (6) @(negedge clk_i);
      wr(8'h07, 8'h01);
      wr(8'h08, 8'h00);
      lr = STRAP_DEFAULT[{strap_b, strap_a}];
      rdchk(8'h07, 8'h06);
      rdchk(8'h08, lr);
      outs(RAMP_RESET, lr);
      lockout = 1'b0;
      repeat (5) @(negedge clk_i);
      wr(8'h07, 8'h03);
      rdchk(8'h07, 8'h03);
      $display("lockout test done");
      final_report();
   end
endmodule : test_dvm_regs
